// file: dbg_event_defines.svh
// Constants for the debug event detector: register offsets, field positions,
// reset values. Assumes a 32-bit APB slave with word-aligned registers.
//
// Behaviour
// RULE_01: Of cache operations only line-zero raises a value match event.
// RULE_02: Conditional store without reservation raises no value match event.
// RULE_03: String load/store with zero byte count raises no value match.
// RULE_04: Taken branch event when enabled and branch redirects the stream.
// RULE_05: External/wait mode: branch sets status, suppressed, stop at branch.
// RULE_06: Internal mode, irq allowed: branch suppressed, debug irq at it.
// RULE_07: Internal-only mode with irq disallowed: no taken branch event.
// RULE_08: Trace mode: branch, trap, return set status and trace only.
// RULE_09: Trap event when enabled and trap condition of trap word holds.
// RULE_10: Trap: stop at trap address, or debug irq saving it.
// RULE_11: Internal-only, irq off: trap sets status, imprecise, program trap.
// RULE_12: Exit handler event when enabled and a return is attempted.
// RULE_13: Return: status set, suppressed, stop or debug irq at its pc.
// RULE_14: Internal-only, irq off: only interrupt return raises exit event.
// RULE_15: That return sets status, imprecise; unsuppressed, delayed irq.
// RULE_16: Completion event when enabled and any instruction completes.
// RULE_17: External/wait: complete event stops at next pc, branch target.
// RULE_18: Completion of a return stops at the address sequentially after it.
// RULE_19: Internal, irq allowed: complete event raises irq, saves next pc.
// RULE_20: Internal-only, irq disallowed: no instruction complete events.
// RULE_21: Software enables complete event only with a non-trace debug mode.
// RULE_22: External/wait beats internal, which beats trace-only handling.
`ifndef DBG_EVENT_DEFINES_SVH
`define DBG_EVENT_DEFINES_SVH

// Register byte offsets
`define OFS_CONTROL_0 12'h000
`define OFS_STATUS 12'h004
`define OFS_SAVE_PC 12'h008
`define OFS_MACHINE 12'h00C

// Control fields
`define CTL_EXT_MODE 0
`define CTL_WAIT_MODE 1
`define CTL_INT_MODE 2
`define CTL_TRACE_MODE 3
`define CTL_BRT_EN 4
`define CTL_TRAP_EN 5
`define CTL_RET_EN 6
`define CTL_INSTR_COMPLETE_EVENT_EN 7
`define CTL_DVC_EN 8
`define CTL_WIDTH 9

// Status fields
`define STS_BRT 0
`define STS_TRAP 1
`define STS_RET 2
`define STS_INSTR_COMPLETE_EVENT 3
`define STS_DVC 4
`define STS_IDE 5
`define STS_WIDTH 6

// Machine state field
`define MSR_IRQ_ALLOW 0

// Reset values
`define CTL_RESET 9'h000
`define STS_RESET 6'h00

`endif

// file: dbg_event_pkg.sv
// Types for the debug event detector.
// Assumes the constants header is compiled alongside.
`default_nettype none
package dbg_event_pkg;

  // Classes of instruction presented by the pipeline
  typedef enum logic [3:0] {
    OP_OTHER = 4'h0,
    OP_BRANCH = 4'h1,
    OP_TRAP = 4'h2,
    OP_RFI = 4'h3,
    OP_RFCI = 4'h4,
    OP_RFMCI = 4'h5,
    OP_LINE_ZERO = 4'h6,
    OP_CACHE_OTHER = 4'h7,
    OP_STORE_COND = 4'h8,
    OP_STRING = 4'h9,
    OP_LOAD_STORE = 4'hA
  } op_class_e;

  // How the current event is handled
  typedef enum logic [3:0] {
    ACT_NONE = 4'h1,
    ACT_STOP = 4'h2,
    ACT_IRQ = 4'h4,
    ACT_RECORD = 4'h8
  } action_e;

endpackage : dbg_event_pkg
`default_nettype wire

// file: debug_event_detector.sv
// Debug event detector: classifies attempted and completed instructions
// against the debug control setting and decides record, suppress, stop or
// debug interrupt. Assumes the pipeline presents one instruction per cycle
// and holds the core once stop or a debug interrupt is signalled.
//
// Design decisions made here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "dbg_event_defines.svh"

module debug_event_detector #(
  parameter int ADDR_W = 32
) (
  input wire logic clk,
  input wire logic rstn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Attempt stage
  input wire logic att_valid,
  input wire dbg_event_pkg::op_class_e att_op,
  input wire logic [ADDR_W-1:0] att_pc,
  input wire logic branch_taken,
  input wire logic trap_cond,
  input wire logic has_reservation,
  input wire logic [6:0] string_byte_count,
  input wire logic value_match_hit,
  // Completion stage
  input wire logic cmp_valid,
  input wire dbg_event_pkg::op_class_e cmp_op,
  input wire logic [ADDR_W-1:0] cmp_pc,
  input wire logic [ADDR_W-1:0] cmp_next_pc,
  // Status back to the core
  output logic suppress,
  output logic program_trap,
  output logic stop_req,
  output logic debug_irq,
  output logic [ADDR_W-1:0] stop_pc,
  output logic [ADDR_W-1:0] critical_save_pc,
  output logic trace_valid,
  output logic [3:0] trace_event
);
  import dbg_event_pkg::*;

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [`CTL_WIDTH-1:0] debug_control_0;
  logic [`STS_WIDTH-1:0] debug_status_reg;
  logic dbg_irq_allow;
  logic ext_mode, int_only, halt_mode, irq_ok, irq_blocked;
  logic wr_en, rd_en;
  logic [`STS_WIDTH-1:0] set_bits;
  logic [`STS_WIDTH-1:0] clr_bits;
  logic wr_msr_de;
  logic pending_hit;

  // Fixed-latency slave, zero wait states
  assign pready = 1'b1;
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & penable & ~pwrite;

  // Decode of an address to a known register
  function automatic logic is_mapped(input logic [11:0] a);
    is_mapped = (a == `OFS_CONTROL_0) || (a == `OFS_STATUS) ||
                (a == `OFS_SAVE_PC) || (a == `OFS_MACHINE);
  endfunction : is_mapped

  assign pslverr = psel & penable & ~is_mapped(paddr);

  // Mode decode, shared by all event types except value match
  assign ext_mode = debug_control_0[`CTL_EXT_MODE] |
                    debug_control_0[`CTL_WAIT_MODE];
  assign halt_mode = ext_mode;
  assign int_only = ~ext_mode & debug_control_0[`CTL_INT_MODE];
  assign irq_ok = int_only & dbg_irq_allow;
  assign irq_blocked = int_only & ~dbg_irq_allow;

  // Control register, written by software only
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      debug_control_0 <= `CTL_RESET;
    end else if (wr_en && paddr == `OFS_CONTROL_0) begin
      debug_control_0 <= pwdata[`CTL_WIDTH-1:0];
    end
  end

  // Interrupt-allow bit of the machine state
  assign wr_msr_de = wr_en && paddr == `OFS_MACHINE;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dbg_irq_allow <= 1'b0;
    end else if (wr_msr_de) begin
      dbg_irq_allow <= pwdata[`MSR_IRQ_ALLOW];
    end
  end

  // ****************************************************************
  // Event detection
  // ****************************************************************
  logic brt_hit, trap_hit, ret_hit, instr_complete_event_hit, dvc_hit;
  logic is_ret_att, is_ret_cmp;
  action_e act;
  logic [ADDR_W-1:0] act_pc;

  assign is_ret_att = att_op inside {OP_RFI, OP_RFCI, OP_RFMCI};
  assign is_ret_cmp = cmp_op inside {OP_RFI, OP_RFCI, OP_RFMCI};

  // Stream-redirecting branches only; never in internal-only blocked mode
  assign brt_hit = att_valid && debug_control_0[`CTL_BRT_EN] &&
                   att_op == OP_BRANCH && branch_taken && // see RULE_04
                   !irq_blocked; // see RULE_07
  assign trap_hit = att_valid && debug_control_0[`CTL_TRAP_EN] &&
                    att_op == OP_TRAP && trap_cond; // see RULE_09
  // Critical returns stay clear of events while irqs are blocked
  assign ret_hit = att_valid && debug_control_0[`CTL_RET_EN] &&
                   is_ret_att && // see RULE_12
                   !(irq_blocked && att_op != OP_RFI); // see RULE_14
  // Trace-only completion events are unsupported and dropped
  assign instr_complete_event_hit = cmp_valid && // see RULE_16
                    debug_control_0[`CTL_INSTR_COMPLETE_EVENT_EN] &&
                    (ext_mode || irq_ok); // see RULE_20, RULE_21

  // Value match filtered by instructions that really access storage
  always_comb begin
    dvc_hit = att_valid && debug_control_0[`CTL_DVC_EN] && value_match_hit;
    unique case (att_op)
      OP_LINE_ZERO: dvc_hit = dvc_hit; // see RULE_01
      OP_CACHE_OTHER: dvc_hit = 1'b0; // see RULE_01
      OP_STORE_COND: dvc_hit = dvc_hit && has_reservation; // see RULE_02
      OP_STRING: dvc_hit = dvc_hit && // see RULE_03
                           string_byte_count != 7'h00;
      OP_LOAD_STORE: dvc_hit = dvc_hit;
      default: dvc_hit = 1'b0;
    endcase
  end

  // Action choice: halt beats internal beats trace
  always_comb begin
    act = ACT_NONE;
    act_pc = att_pc;
    set_bits = '0;
    suppress = 1'b0;
    program_trap = 1'b0;
    set_bits[`STS_DVC] = dvc_hit;
    if (brt_hit || trap_hit || ret_hit) begin
      set_bits[`STS_BRT] = brt_hit;
      set_bits[`STS_TRAP] = trap_hit;
      set_bits[`STS_RET] = ret_hit;
      if (halt_mode) begin // see RULE_22
        act = ACT_STOP; // see RULE_05, RULE_10, RULE_13
        suppress = 1'b1;
      end else if (irq_ok) begin
        act = ACT_IRQ; // see RULE_06, RULE_10, RULE_13
        suppress = 1'b1;
      end else if (irq_blocked) begin
        set_bits[`STS_IDE] = 1'b1; // see RULE_11, RULE_15
        suppress = trap_hit; // see RULE_11
        program_trap = trap_hit;
        act = ACT_RECORD;
      end else begin
        act = ACT_RECORD; // see RULE_08
      end
    end else if (instr_complete_event_hit) begin
      set_bits[`STS_INSTR_COMPLETE_EVENT] = 1'b1;
      // Next pc from the pipeline is the target after a taken branch
      act_pc = is_ret_cmp ? cmp_pc + ADDR_W'(4) : cmp_next_pc; // see RULE_18
      act = halt_mode ? ACT_STOP : ACT_IRQ; // see RULE_17, RULE_19
    end
  end

  // Status bits, set wins over a same-cycle software clear
  assign clr_bits = (wr_en && paddr == `OFS_STATUS) ?
                    pwdata[`STS_WIDTH-1:0] : '0;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      debug_status_reg <= `STS_RESET;
    end else begin
      debug_status_reg <= (debug_status_reg & ~clr_bits) | set_bits;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Pending imprecise status fires once irqs are allowed again
  assign pending_hit = irq_ok && act == ACT_NONE &&
                       debug_status_reg[`STS_IDE] &&
                       |debug_status_reg[`STS_INSTR_COMPLETE_EVENT:`STS_BRT]; // see RULE_11

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stop_req <= 1'b0;
      debug_irq <= 1'b0;
      stop_pc <= '0;
      critical_save_pc <= '0;
      trace_valid <= 1'b0;
      trace_event <= 4'h0;
    end else begin
      stop_req <= act == ACT_STOP;
      debug_irq <= act == ACT_IRQ || pending_hit; // see RULE_15
      trace_valid <= act == ACT_RECORD && !int_only; // see RULE_08
      trace_event <= {set_bits[`STS_INSTR_COMPLETE_EVENT], set_bits[`STS_RET],
                      set_bits[`STS_TRAP], set_bits[`STS_BRT]};
      if (act == ACT_STOP) begin
        stop_pc <= act_pc;
      end
      if (act == ACT_IRQ) begin
        critical_save_pc <= act_pc;
      end else if (pending_hit) begin
        critical_save_pc <= att_pc;
      end
    end
  end

  // Register read mux
  always_comb begin
    prdata = 32'h0000_0000;
    if (rd_en) begin
      unique case (paddr)
        `OFS_CONTROL_0: prdata = 32'(debug_control_0);
        `OFS_STATUS: prdata = 32'(debug_status_reg);
        `OFS_SAVE_PC: prdata = 32'(critical_save_pc);
        `OFS_MACHINE: prdata = {31'h0, dbg_irq_allow};
        default: prdata = 32'h0000_0000;
      endcase
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_brt_stop;
    @(posedge clk) disable iff (!rstn)
    brt_hit && halt_mode |-> suppress ##1 stop_req && stop_pc == $past(att_pc);
  endproperty
  a_brt_stop: assert property (p_brt_stop) // see RULE_05
    else $error("branch in halt mode did not stop");

  property p_brt_irq;
    @(posedge clk) disable iff (!rstn)
    brt_hit && irq_ok |=> debug_irq && critical_save_pc == $past(att_pc);
  endproperty
  a_brt_irq: assert property (p_brt_irq) // see RULE_06
    else $error("branch irq missing");

  property p_brt_blocked;
    @(posedge clk) disable iff (!rstn)
    irq_blocked && att_valid && att_op == OP_BRANCH &&
      !debug_status_reg[`STS_BRT] |=> !debug_status_reg[`STS_BRT];
  endproperty
  a_brt_blocked: assert property (p_brt_blocked) // see RULE_07
    else $error("event in blocked internal mode");

  property p_trap_blocked;
    @(posedge clk) disable iff (!rstn)
    trap_hit && irq_blocked |-> program_trap && suppress
      ##1 debug_status_reg[`STS_IDE] && !debug_irq;
  endproperty
  a_trap_blocked: assert property (p_trap_blocked) // see RULE_11
    else $error("blocked trap handling wrong");

  property p_ret_crit;
    @(posedge clk) disable iff (!rstn)
    irq_blocked && att_op inside {OP_RFCI, OP_RFMCI} |-> !ret_hit;
  endproperty
  a_ret_crit: assert property (p_ret_crit) // see RULE_14
    else $error("critical return raised event");

  property p_rfi_blocked;
    @(posedge clk) disable iff (!rstn)
    ret_hit && irq_blocked |-> !suppress ##1 debug_status_reg[`STS_RET];
  endproperty
  a_rfi_blocked: assert property (p_rfi_blocked) // see RULE_15
    else $error("blocked return suppressed or unrecorded");

  property p_instr_complete_event_ret_pc;
    @(posedge clk) disable iff (!rstn)
    instr_complete_event_hit && halt_mode && act == ACT_STOP && is_ret_cmp &&
      !(brt_hit || trap_hit || ret_hit)
      |=> stop_pc == $past(cmp_pc) + ADDR_W'(4);
  endproperty
  a_instr_complete_event_ret_pc: assert property (p_instr_complete_event_ret_pc) // see RULE_18
    else $error("return completion pc wrong");

  property p_trace_cont;
    @(posedge clk) disable iff (!rstn)
    (brt_hit || trap_hit) && !ext_mode && !int_only
      |-> !suppress ##1 trace_valid;
  endproperty
  a_trace_cont: assert property (p_trace_cont) // see RULE_08
    else $error("trace event suppressed or untraced");

  property p_dvc_string;
    @(posedge clk) disable iff (!rstn)
    att_op == OP_STRING && string_byte_count == 7'h00
      |=> !debug_status_reg[`STS_DVC] ||
          $past(debug_status_reg[`STS_DVC]);
  endproperty
  a_dvc_string: assert property (p_dvc_string) // see RULE_03
    else $error("zero-length string matched");

  property p_dvc_cache;
    @(posedge clk) disable iff (!rstn)
    att_valid && att_op == OP_CACHE_OTHER && !debug_status_reg[`STS_DVC]
      |=> !debug_status_reg[`STS_DVC];
  endproperty
  a_dvc_cache: assert property (p_dvc_cache) // see RULE_01
    else $error("non-zeroing cache operation matched");

  property p_dvc_cond;
    @(posedge clk) disable iff (!rstn)
    att_valid && att_op == OP_STORE_COND && !has_reservation &&
      !debug_status_reg[`STS_DVC] |=> !debug_status_reg[`STS_DVC];
  endproperty
  a_dvc_cond: assert property (p_dvc_cond) // see RULE_02
    else $error("store without reservation matched");

  property p_trap_halt;
    @(posedge clk) disable iff (!rstn)
    trap_hit && halt_mode |-> suppress
      ##1 stop_req && stop_pc == $past(att_pc);
  endproperty
  a_trap_halt: assert property (p_trap_halt) // see RULE_10
    else $error("trap in halt mode did not stop");

  property p_ret_seen;
    @(posedge clk) disable iff (!rstn)
    att_valid && debug_control_0[`CTL_RET_EN] && att_op == OP_RFI
      |=> debug_status_reg[`STS_RET];
  endproperty
  a_ret_seen: assert property (p_ret_seen) // see RULE_12
    else $error("interrupt return not recorded");

  property p_ret_irq;
    @(posedge clk) disable iff (!rstn)
    ret_hit && irq_ok |-> suppress
      ##1 debug_irq && critical_save_pc == $past(att_pc);
  endproperty
  a_ret_irq: assert property (p_ret_irq) // see RULE_13
    else $error("return irq missing");

  property p_instr_complete_event_stop;
    @(posedge clk) disable iff (!rstn)
    instr_complete_event_hit && halt_mode && !is_ret_cmp &&
      !(brt_hit || trap_hit || ret_hit)
      |=> stop_req && stop_pc == $past(cmp_next_pc);
  endproperty
  a_instr_complete_event_stop: assert property (p_instr_complete_event_stop) // see RULE_17
    else $error("completion stop pc wrong");

  property p_instr_complete_event_irq;
    @(posedge clk) disable iff (!rstn)
    instr_complete_event_hit && irq_ok && !is_ret_cmp &&
      !(brt_hit || trap_hit || ret_hit)
      |=> debug_irq && critical_save_pc == $past(cmp_next_pc);
  endproperty
  a_instr_complete_event_irq: assert property (p_instr_complete_event_irq) // see RULE_19
    else $error("completion irq or saved pc wrong");

  property p_instr_complete_event_blocked;
    @(posedge clk) disable iff (!rstn)
    irq_blocked && cmp_valid && !debug_status_reg[`STS_INSTR_COMPLETE_EVENT]
      |=> !debug_status_reg[`STS_INSTR_COMPLETE_EVENT];
  endproperty
  a_instr_complete_event_blocked: assert property (p_instr_complete_event_blocked) // see RULE_20
    else $error("completion event in blocked internal mode");

  property p_halt_first;
    @(posedge clk) disable iff (!rstn)
    (brt_hit || trap_hit || ret_hit) && halt_mode &&
      debug_control_0[`CTL_INT_MODE] |=> stop_req && !debug_irq;
  endproperty
  a_halt_first: assert property (p_halt_first) // see RULE_22
    else $error("internal handling beat halt mode");

  c_stop: cover property (@(posedge clk) disable iff (!rstn) stop_req);
  c_irq: cover property (@(posedge clk) disable iff (!rstn) debug_irq);
  c_pend: cover property (@(posedge clk) disable iff (!rstn) pending_hit);
  c_trace: cover property (@(posedge clk) disable iff (!rstn) trace_valid);
  c_ptrap: cover property (@(posedge clk) disable iff (!rstn) program_trap);

endmodule : debug_event_detector
`default_nettype wire

// file: pipe_model.sv
// Pipeline stand-in: presents one attempt or completion slot per call.
// Assumes the bench owns clock and reset and calls issue() in sequence.
`timescale 1ns/1ps
`default_nettype none
module pipe_model (
  input wire logic clk,
  input wire logic suppress,
  input wire logic program_trap,
  output var logic att_valid,
  output var dbg_event_pkg::op_class_e att_op,
  output var logic [31:0] att_pc,
  output var logic branch_taken,
  output var logic trap_cond,
  output var logic has_reservation,
  output var logic [6:0] string_byte_count,
  output var logic value_match_hit,
  output var logic cmp_valid,
  output var dbg_event_pkg::op_class_e cmp_op,
  output var logic [31:0] cmp_pc,
  output var logic [31:0] cmp_next_pc
);
  import dbg_event_pkg::*;
  // ****************
  // Slot driver
  // ****************
  // Quiet pipeline at time zero
  initial begin
    {att_valid, cmp_valid, branch_taken, trap_cond} = 4'h0;
    {has_reservation, value_match_hit} = 2'h0;
    string_byte_count = 7'h00;
    att_op = OP_OTHER;
    cmp_op = OP_OTHER;
    {att_pc, cmp_pc, cmp_next_pc} = 96'h0;
  end

  // One slot; idle pc lines flip so a stale copy is never mistaken for data
  task automatic issue(input logic att, input op_class_e op,
    input logic [31:0] pc, input logic [31:0] nxt, input logic tk,
    input logic rs, input logic [6:0] n, output logic sup, output logic pt);
    @(posedge clk);
    att_valid <= att;
    cmp_valid <= !att;
    att_op <= op;
    cmp_op <= op;
    {att_pc, cmp_pc, cmp_next_pc} <= {pc, pc, nxt};
    branch_taken <= tk;
    trap_cond <= tk;
    has_reservation <= rs;
    string_byte_count <= n;
    value_match_hit <= 1'h1;
    #1;
    sup = suppress;
    pt = program_trap;
    @(posedge clk);
    {att_valid, cmp_valid, value_match_hit} <= 3'h0;
    {att_pc, cmp_pc, cmp_next_pc} <= ~{pc, pc, nxt};
    #1;
  endtask : issue
endmodule : pipe_model
`default_nettype wire

// file: debug_event_detector_tb.sv
// Self-checking bench: APB register access, then branch, trap, return and
// completion events in every debug mode against a bench model, value match
// in trace mode only. Design files compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "dbg_event_defines.svh"
module debug_event_detector_tb;
  import dbg_event_pkg::*;
  // Trace mode leaves completion events off
  localparam logic [8:0] MODES [6] = '{9'h0F1, 9'h0F2, 9'h0F4, 9'h0F4,
    9'h078, 9'h0F5};
  localparam op_class_e OPS [9] = '{OP_BRANCH, OP_TRAP, OP_RFI, OP_RFCI,
    OP_RFMCI, OP_OTHER, OP_RFI, OP_BRANCH, OP_BRANCH};
  localparam op_class_e VOP [7] = '{OP_LINE_ZERO, OP_CACHE_OTHER,
    OP_STORE_COND, OP_STORE_COND, OP_STRING, OP_STRING, OP_LOAD_STORE};
  localparam logic [6:0] DEX = 7'h69;
  logic clk, rstn, psel, penable, pwrite, pready, pslverr, err, sup, pt;
  logic att_valid, branch_taken, trap_cond, has_reservation, value_match_hit;
  logic cmp_valid, suppress, program_trap, stop_req, debug_irq, trace_valid;
  logic allow, esup, ept, estop, eirq;
  logic [3:0] trace_event, etr;
  logic [6:0] string_byte_count;
  logic [8:0] ctl;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, apc, nxt, ests, epc;
  logic [31:0] att_pc, cmp_pc, cmp_next_pc, stop_pc, critical_save_pc;
  op_class_e att_op, cmp_op;
  int errors = 0;
  int checks_done = 0;
  int cyc = 0;

  debug_event_detector debug_event_detector_inst (.clk, .rstn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .att_valid, .att_op, .att_pc, .branch_taken, .trap_cond,
    .has_reservation, .string_byte_count, .value_match_hit, .cmp_valid,
    .cmp_op, .cmp_pc, .cmp_next_pc, .suppress, .program_trap, .stop_req,
    .debug_irq, .stop_pc, .critical_save_pc, .trace_valid, .trace_event);
  pipe_model pipe_model_inst (.clk, .suppress, .program_trap, .att_valid,
    .att_op, .att_pc, .branch_taken, .trap_cond, .has_reservation,
    .string_byte_count, .value_match_hit, .cmp_valid, .cmp_op, .cmp_pc,
    .cmp_next_pc);

  // ****************
  // Clock, watchdog, helpers
  // ****************
  // 100 MHz clock
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  // Hang guard, far above the roughly 600 cycles the run needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      errors = errors + 1;
      print_verdict();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  // One APB transfer; waits on pready rather than assuming zero waits
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    @(posedge clk);
    // Only the watchdog ends a wait that never sees pready
    while (pready !== 1'h1) begin
      @(posedge clk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  // Expected reaction to slot k under the current mode
  task automatic model(input int k);
    int b;
    logic ev, hard, intm;
    hard = ctl[0] | ctl[1];
    intm = ctl[2] & !hard;
    b = (k == 0 || k == 8) ? 0 : (k == 1) ? 1 : (k < 5) ? 2 : 3;
    ev = (k != 8) && ctl[4 + b];
    {esup, ept, estop, eirq, etr} = 8'h00;
    ests = 32'h0;
    epc = (k < 5) ? apc : (k == 6) ? apc + 32'h4 : nxt;
    if (ev && (hard || (intm && allow))) begin
      ests = 32'h1 << b;
      esup = k < 5;
      estop = hard;
      eirq = !hard;
    end else if (ev && intm && (k == 1 || k == 2)) begin
      ests = (32'h1 << b) | 32'h20;
      esup = k == 1;
      ept = k == 1;
    end else if (ev && !intm) begin
      ests = 32'h1 << b;
      etr = 4'h1 << b;
    end
  endtask : model

  task automatic print_verdict();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : print_verdict

  // ****************
  // Main sequence
  // ****************
  initial begin
    {rstn, psel, penable, pwrite} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    void'($urandom(32'h4d1300ed));
    repeat (12) @(posedge clk);
    rstn <= 1'h1;
    // Reset values, read-only save pc, then one unmapped offset
    apb(1'h1, `OFS_SAVE_PC, 32'hFFFF_FFFF);
    for (int a = 0; a < 5; a++) begin
      apb(1'h0, 12'(a * 4), 32'h0);
      chk("reset_rd", 32'h0, rd);
      chk("slverr", 32'(a == 4), 32'(err));
      chk("pready", 32'h1, 32'(pready));
    end
    for (int m = 0; m < 6; m++) begin
      ctl = MODES[m];
      allow = (m == 2 || m == 5);
      apb(1'h1, `OFS_CONTROL_0, {23'h0, ctl});
      apb(1'h1, `OFS_MACHINE, {31'h0, allow});
      apb(1'h0, `OFS_CONTROL_0, 32'h0);
      chk("control", {23'h0, ctl}, rd);
      for (int k = 0; k < 9; k++) begin
        apc = $urandom & 32'hFFFF_FFFC;
        nxt = $urandom & 32'hFFFF_FFFC;
        model(k);
        pipe_model_inst.issue(k < 5 || k == 8, OPS[k], apc, nxt, k != 8,
          1'h0, 7'h00, sup, pt);
        chk("suppress", 32'(esup), 32'(sup));
        chk("prog_trap", 32'(ept), 32'(pt));
        chk("stop_req", 32'(estop), 32'(stop_req));
        chk("debug_irq", 32'(eirq), 32'(debug_irq));
        chk("trace", 32'(etr),
          trace_valid ? 32'(trace_event) : 32'h0);
        if (estop) chk("stop_pc", epc, stop_pc);
        if (eirq) chk("save_pc", epc, critical_save_pc);
        apb(1'h0, `OFS_STATUS, 32'h0);
        chk("status", ests, rd);
        // Delayed interrupt once allowed, gone once status is cleared
        if (ests[5]) begin
          apb(1'h1, `OFS_MACHINE, 32'h1);
          @(posedge clk);
          #1;
          chk("late_irq", 32'h1, 32'(debug_irq));
          apb(1'h1, `OFS_STATUS, 32'h3F);
          @(posedge clk);
          #1;
          chk("irq_drop", 32'h0, 32'(debug_irq));
          apb(1'h1, `OFS_MACHINE, 32'h0);
        end
        apb(1'h1, `OFS_STATUS, 32'h3F);
      end
    end
    // Value match special cases, trace mode with the match enable on
    apb(1'h1, `OFS_CONTROL_0, 32'h108);
    apb(1'h1, `OFS_MACHINE, 32'h0);
    for (int i = 0; i < 7; i++) begin
      pipe_model_inst.issue(1'h1, VOP[i], apc, nxt, 1'h1, i == 3,
        (i == 5) ? 7'($urandom_range(127, 1)) : 7'h00, sup, pt);
      apb(1'h0, `OFS_STATUS, 32'h0);
      chk("vm", 32'(DEX[i]), 32'(rd[4]));
      apb(1'h1, `OFS_STATUS, 32'h3F);
    end
    print_verdict();
  end
endmodule : debug_event_detector_tb
`default_nettype wire
